// File: hdl/sac_pkg.sv
// Package with register map, field layout and timing constants.
package sac_pkg;
   // Register addresses on the special-register bus
   localparam logic [7:0] ADDR_PAIR_CFG   = 8'hba;
   localparam logic [7:0] ADDR_CHAN_SEL   = 8'hbb;
   localparam logic [7:0] ADDR_CONV_CFG   = 8'hbc;
   localparam logic [7:0] ADDR_CONV_CTRL  = 8'he8;
   localparam logic [7:0] ADDR_RES_LOW    = 8'hbe;
   localparam logic [7:0] ADDR_RES_HIGH   = 8'hbf;
   // Reset values
   localparam logic [7:0] RST_PAIR_CFG    = 8'h00;
   localparam logic [7:0] RST_CHAN_SEL    = 8'h00;
   localparam logic [7:0] RST_CONV_CFG    = 8'h60;
   localparam logic [7:0] RST_CONV_CTRL   = 8'h00;
   // Writable masks; unused bits stay zero
   localparam logic [7:0] MASK_PAIR_CFG   = 8'h0f;
   localparam logic [7:0] MASK_CHAN_SEL   = 8'h0f;
   localparam logic [7:0] MASK_CONV_CFG   = 8'he7;
   // Control register bit positions
   localparam int BIT_ENABLE     = 7;
   localparam int BIT_TRACK_MODE = 6;
   localparam int BIT_DONE       = 5;
   localparam int BIT_BUSY       = 4;
   localparam int BIT_STM_HI     = 3;
   localparam int BIT_STM_LO     = 2;
   localparam int BIT_WINDOW     = 1;
   localparam int BIT_LJUST      = 0;
   // Configuration register fields
   localparam int CFG_DIV_HI     = 7;
   localparam int CFG_DIV_LO     = 5;
   localparam int CFG_GAIN_HI    = 2;
   // Start-mode encodings
   localparam logic [1:0] STM_SOFTWARE = 2'h0;
   localparam logic [1:0] STM_TIMER3   = 2'h1;
   localparam logic [1:0] STM_EXTERNAL = 2'h2;
   localparam logic [1:0] STM_TIMER2   = 2'h3;
   // Conversion-clock counts and result width
   localparam logic [4:0] TRACK_CLOCKS = 5'h03;
   localparam logic [4:0] CONV_CLOCKS  = 5'h10;
   localparam logic [4:0] DIV_MAX      = 5'h10;
   localparam int         RES_BITS     = 10;
   // Conversion-clock period for a divider code
   function automatic logic [4:0] sac_div_period(input logic [2:0] code);
      logic [4:0] p;
      p = DIV_MAX;
      if (code[2] == 1'b0) begin
         p = 5'(5'h01 << code[1:0]);
      end
      return p;
   endfunction : sac_div_period
endpackage : sac_pkg

// File: hdl/sac_clock_divider.sv
// Conversion clock tick generator dividing the system clock.
`timescale 1ns/100ps
module sac_clock_divider
   import sac_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       rstn,
   input  wire logic       restart,
   input  wire logic [2:0] divCode,
   output logic            tick
);
   logic [4:0] count_q;
   logic [4:0] period;
   logic       atEnd;

   assign period = sac_div_period(divCode);
   assign atEnd  = (count_q >= period - 5'h01);
   // Tick is combinational so the first period after a restart is full
   // length and not one system clock longer
   assign tick   = atEnd && !restart;

   // Count system clocks in each period; restart aligns phase
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         count_q <= 5'h00;
      end else if (restart) begin
         count_q <= 5'h00;
      end else if (atEnd) begin
         count_q <= 5'h00;
      end else begin
         count_q <= count_q + 5'h01;
      end
   end
endmodule : sac_clock_divider

// File: hdl/sac_start_sync.sv
// Two-stage synchroniser and rising-edge detector for the start pin.
`timescale 1ns/100ps
module sac_start_sync
   import sac_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic rstn,
   input  wire logic pinIn,
   output logic      level,
   output logic      rise
);
   logic meta_q;
   logic sync_q;
   logic last_q;

   // Only sync_q reads meta_q; edge logic looks at later stages
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         last_q <= 1'b0;
      end else begin
         meta_q <= pinIn;
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end

   assign level = sync_q;
   assign rise  = sync_q & ~last_q;
endmodule : sac_start_sync

// File: hdl/sac_conversion_control.sv
// Top of the converter control: registers, triggers, sequencing, result.
`timescale 1ns/100ps
module sac_conversion_control
   import sac_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       rstn,
   input  wire logic [7:0] regAddr,
   input  wire logic [7:0] regWrData,
   input  wire logic       regWrEn,
   input  wire logic       regRdEn,
   output logic [7:0]      regRdData,
   input  wire logic       timer2Overflow,
   input  wire logic       timer3Overflow,
   input  wire logic       externalConvertStart,
   input  wire logic       windowMatch,
   input  wire logic       sarBitValid,
   input  wire logic [9:0] sarResult,
   output logic            converterPowered,
   output logic            trackActive,
   output logic            holdConvert,
   output logic            sarStep,
   output logic            conversionDoneIrq,
   output logic [3:0]      channelSelectCode,
   output logic            tempSensorSelect,
   output logic [2:0]      muxPositive,
   output logic            muxDifferential,
   output logic [2:0]      amplifierGainCode,
   output logic [2:0]      gainShift,
   output logic            gainHalf,
   output logic [7:0]      resultHighByte,
   output logic [7:0]      resultLowByte
);
   typedef enum logic [1:0] {
      SAC_IDLE,
      SAC_TRACK,
      SAC_CONVERT
   } sac_state_e;

   sac_state_e state_q;
   logic [7:0] pairCfg_q;
   logic [7:0] chanSel_q;
   logic [7:0] convCfg_q;
   logic       enable_q;
   logic       trackMode_q;
   logic       doneFlag_q;
   logic       windowFlag_q;
   logic [1:0] startMode_q;
   logic       leftJustify_q;
   logic [4:0] clkCount_q;
   logic       convDiff_q;
   logic       busy;
   logic       wrCtrl;
   logic       trigger;
   logic       sarTick;
   logic       divRestart;
   logic       extLevel;
   logic       extRise;
   logic       finishing;
   logic       pairDiff;

   // Pair decode shared by mux steering and result sign handling;
   // the sensor code is never part of a pair
   function automatic logic chan_is_diff(input logic [3:0] code,
                                         input logic [3:0] pairs);
      logic diff;
      diff = 1'b0;
      if (code[3] == 1'b0) begin
         diff = pairs[code[2:1]];
      end
      return diff;
   endfunction : chan_is_diff

   // Divider phase restarts whenever the sequencer is idle
   sac_clock_divider u_divider (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .restart (divRestart),
      .divCode (convCfg_q[CFG_DIV_HI:CFG_DIV_LO]),
      .tick    (sarTick)
   );

   // Start pin passes two flops before its edge is seen
   sac_start_sync u_start_sync (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .pinIn   (externalConvertStart),
      .level   (extLevel),
      .rise    (extRise)
   );

   assign wrCtrl = regWrEn && (regAddr == ADDR_CONV_CTRL);
   assign busy   = (state_q != SAC_IDLE);

   // Trigger selection by start mode
   always_comb begin
      unique case (startMode_q)
         STM_SOFTWARE: trigger = wrCtrl && regWrData[BIT_BUSY];
         STM_TIMER3:   trigger = timer3Overflow;
         STM_EXTERNAL: trigger = extRise;
         STM_TIMER2:   trigger = timer2Overflow;
      endcase
   end

   // Divider restarts while idle so the first track clock is full length
   assign divRestart = (state_q == SAC_IDLE);
   assign finishing  = (state_q == SAC_CONVERT) && sarTick &&
                       (clkCount_q == CONV_CLOCKS - 5'h01);

   // Sequencer; triggers during a conversion are ignored
   // Clearing enable aborts a conversion without a done flag
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state_q    <= SAC_IDLE;
         clkCount_q <= 5'h00;
      end else if (!enable_q) begin
         state_q    <= SAC_IDLE;
         clkCount_q <= 5'h00;
      end else begin
         unique case (state_q)
            SAC_IDLE: begin
               clkCount_q <= 5'h00;
               if (trigger) begin
                  // Track first only in low-power internal modes
                  if (trackMode_q && startMode_q != STM_EXTERNAL) begin
                     state_q <= SAC_TRACK;
                  end else begin
                     state_q <= SAC_CONVERT;
                  end
               end
            end
            SAC_TRACK: begin
               if (sarTick) begin
                  if (clkCount_q == TRACK_CLOCKS - 5'h01) begin
                     state_q    <= SAC_CONVERT;
                     clkCount_q <= 5'h00;
                  end else begin
                     clkCount_q <= clkCount_q + 5'h01;
                  end
               end
            end
            SAC_CONVERT: begin
               if (finishing) begin
                  state_q    <= SAC_IDLE;
                  clkCount_q <= 5'h00;
               end else if (sarTick) begin
                  clkCount_q <= clkCount_q + 5'h01;
               end
            end
            default: begin
               state_q    <= SAC_IDLE;
               clkCount_q <= 5'h00;
            end
         endcase
      end
   end

   // Plain configuration registers; masked bits never store
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         pairCfg_q <= RST_PAIR_CFG;
         chanSel_q <= RST_CHAN_SEL;
         convCfg_q <= RST_CONV_CFG;
      end else if (regWrEn) begin
         if (regAddr == ADDR_PAIR_CFG) begin
            pairCfg_q <= regWrData & MASK_PAIR_CFG;
         end
         if (regAddr == ADDR_CHAN_SEL) begin
            chanSel_q <= regWrData & MASK_CHAN_SEL;
         end
         if (regAddr == ADDR_CONV_CFG) begin
            convCfg_q <= regWrData & MASK_CONV_CFG;
         end
      end
   end

   // Control fields written by software
   // Busy is not stored; it reads back the sequencer state
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         enable_q      <= RST_CONV_CTRL[BIT_ENABLE];
         trackMode_q   <= RST_CONV_CTRL[BIT_TRACK_MODE];
         startMode_q   <= RST_CONV_CTRL[BIT_STM_HI:BIT_STM_LO];
         leftJustify_q <= RST_CONV_CTRL[BIT_LJUST];
      end else if (wrCtrl) begin
         enable_q      <= regWrData[BIT_ENABLE];
         trackMode_q   <= regWrData[BIT_TRACK_MODE];
         startMode_q   <= regWrData[BIT_STM_HI:BIT_STM_LO];
         leftJustify_q <= regWrData[BIT_LJUST];
      end
   end

   // Sticky flags: a hardware set beats a software clear
   // A written one is stored as written, like any other value
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         doneFlag_q   <= RST_CONV_CTRL[BIT_DONE];
         windowFlag_q <= RST_CONV_CTRL[BIT_WINDOW];
      end else begin
         if (finishing) begin
            doneFlag_q <= 1'b1;
         end else if (wrCtrl) begin
            doneFlag_q <= regWrData[BIT_DONE];
         end
         if (windowMatch) begin
            windowFlag_q <= 1'b1;
         end else if (wrCtrl) begin
            windowFlag_q <= regWrData[BIT_WINDOW];
         end
      end
   end

   // Channel mapping: odd member of a differential pair folds to even
   assign pairDiff = chan_is_diff(chanSel_q[3:0], pairCfg_q[3:0]);

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         channelSelectCode <= RST_CHAN_SEL[3:0];
         tempSensorSelect  <= 1'b0;
         muxPositive       <= 3'h0;
         muxDifferential   <= 1'b0;
      end else begin
         channelSelectCode <= chanSel_q[3:0];
         tempSensorSelect  <= chanSel_q[3];
         muxDifferential   <= pairDiff;
         if (pairDiff) begin
            muxPositive <= {chanSel_q[2:1], 1'b0};
         end else begin
            muxPositive <= chanSel_q[2:0];
         end
      end
   end

   // Gain decode: shift for 1..16, separate half flag
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         amplifierGainCode <= RST_CONV_CFG[CFG_GAIN_HI:0];
         gainShift         <= 3'h0;
         gainHalf          <= 1'b0;
      end else begin
         amplifierGainCode <= convCfg_q[CFG_GAIN_HI:0];
         unique case (convCfg_q[CFG_GAIN_HI:1])
            2'h2:    gainShift <= 3'h4;
            2'h3:    gainShift <= 3'h0;
            default: gainShift <= {1'b0, convCfg_q[1:0]};
         endcase
         gainHalf <= (convCfg_q[CFG_GAIN_HI:1] == 2'h3);
      end
   end

   // Analog control strobes to the converter core
   // Track output follows the mode now in force, not the trigger's
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         converterPowered  <= 1'b0;
         trackActive       <= 1'b0;
         holdConvert       <= 1'b0;
         sarStep           <= 1'b0;
         conversionDoneIrq <= 1'b0;
      end else begin
         converterPowered <= enable_q;
         holdConvert      <= (state_q == SAC_CONVERT);
         sarStep          <= (state_q == SAC_CONVERT) && sarTick;
         conversionDoneIrq <= finishing;
         if (!enable_q) begin
            trackActive <= 1'b0;
         end else if (!trackMode_q) begin
            trackActive <= (state_q != SAC_CONVERT);
         end else if (startMode_q == STM_EXTERNAL) begin
            trackActive <= (state_q == SAC_IDLE) && !extLevel;
         end else begin
            trackActive <= (state_q == SAC_TRACK);
         end
      end
   end

   // Result capture; sign mode latched per conversion
   // Justification is taken when the data arrives, not at the trigger
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         convDiff_q     <= 1'b0;
         resultHighByte <= 8'h00;
         resultLowByte  <= 8'h00;
      end else begin
         if (state_q == SAC_IDLE) begin
            convDiff_q <= pairDiff;
         end
         if (sarBitValid) begin
            if (leftJustify_q) begin
               resultHighByte <= sarResult[RES_BITS-1:2];
               resultLowByte  <= {sarResult[1:0], 6'h00};
            end else begin
               // Sign extension only for two's complement readings
               resultHighByte <= {{6{convDiff_q & sarResult[RES_BITS-1]}},
                                  sarResult[RES_BITS-1:RES_BITS-2]};
               resultLowByte  <= sarResult[7:0];
            end
         end
      end
   end

   // Register read port, registered one cycle after request
   // Reads have no side effects, so polling the flags is safe
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         regRdData <= 8'h00;
      end else if (regRdEn) begin
         unique case (regAddr)
            ADDR_PAIR_CFG:  regRdData <= pairCfg_q;
            ADDR_CHAN_SEL:  regRdData <= chanSel_q;
            ADDR_CONV_CFG:  regRdData <= convCfg_q;
            ADDR_CONV_CTRL: regRdData <= {enable_q, trackMode_q, doneFlag_q,
                                          busy, startMode_q, windowFlag_q,
                                          leftJustify_q};
            ADDR_RES_HIGH:  regRdData <= resultHighByte;
            ADDR_RES_LOW:   regRdData <= resultLowByte;
            default:        regRdData <= 8'h00;
         endcase
      end
   end
endmodule : sac_conversion_control

// File: tb/sac_conversion_chk.sv
// Port-level assertions for the converter control block.
`timescale 1ns/100ps
module sac_conversion_chk
   import sac_pkg::*;
(
   input wire logic       sys_clk,
   input wire logic       rstn,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic       regWrEn,
   input wire logic       regRdEn,
   input wire logic [7:0] regRdData,
   input wire logic       converterPowered,
   input wire logic       trackActive,
   input wire logic       holdConvert,
   input wire logic       sarStep,
   input wire logic       conversionDoneIrq,
   input wire logic [3:0] channelSelectCode,
   input wire logic       tempSensorSelect,
   input wire logic [2:0] amplifierGainCode,
   input wire logic       gainHalf
);
   // One clock domain, so clock and reset are given once
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   chk_power_follow: assert property (
      regWrEn && regAddr == ADDR_CONV_CTRL |->
      ##2 converterPowered == $past(regWrData[BIT_ENABLE], 2))
      else $error("power state does not follow enable write");
   chk_idle_quiet: assert property (
      !converterPowered [*3] |-> !holdConvert && !trackActive)
      else $error("activity while converter is shut down");
   chk_step_in_conv: assert property (
      sarStep |-> holdConvert)
      else $error("conversion step outside conversion");
   chk_irq_single: assert property (
      conversionDoneIrq |=> !conversionDoneIrq)
      else $error("done pulse longer than one cycle");
   chk_irq_at_end: assert property (
      conversionDoneIrq |-> $past(holdConvert) || $past(holdConvert, 2))
      else $error("done pulse without a finished conversion");
   chk_chan_follow: assert property (
      regWrEn && regAddr == ADDR_CHAN_SEL |->
      ##2 channelSelectCode == $past(regWrData[3:0], 2))
      else $error("channel code does not follow write");
   chk_sensor_sel: assert property (
      tempSensorSelect == channelSelectCode[3])
      else $error("sensor select disagrees with channel code");
   chk_gain_half: assert property (
      gainHalf == (amplifierGainCode[2:1] == 2'h3))
      else $error("half gain disagrees with gain code");
   chk_mux_unused: assert property (
      regRdEn && (regAddr == ADDR_PAIR_CFG || regAddr == ADDR_CHAN_SEL)
      |=> regRdData[7:4] == 4'h0)
      else $error("unused multiplexer bits read nonzero");
   chk_cfg_unused: assert property (
      regRdEn && regAddr == ADDR_CONV_CFG |=> regRdData[4:3] == 2'h0)
      else $error("unused configuration bits read nonzero");
   chk_track_excl: assert property (
      !(trackActive && holdConvert))
      else $error("tracking while converting");
endmodule : sac_conversion_chk

bind sac_conversion_control sac_conversion_chk chk (
   .sys_clk, .rstn, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData,
   .converterPowered, .trackActive, .holdConvert, .sarStep,
   .conversionDoneIrq, .channelSelectCode, .tempSensorSelect,
   .amplifierGainCode, .gainHalf);

// File: tb/sac_far_model.sv
// Far-side model: timer overflow pulses and analog result return.
`timescale 1ns/100ps
module sac_far_model
(
   input  wire logic       sys_clk,
   input  wire logic       fireT2,
   input  wire logic       fireT3,
   input  wire logic       holdConvert,
   input  wire logic [9:0] resultValue,
   output logic            timer2Overflow,
   output logic            timer3Overflow,
   output logic            sarBitValid,
   output logic [9:0]      sarResult
);
   logic [1:0] reqSeen = 2'h0;
   logic [1:0] reqUsed = 2'h0;
   logic       holdNow = 1'b0;
   logic       holdWas = 1'b0;

   initial begin
      timer2Overflow = 1'b0;
      timer3Overflow = 1'b0;
      sarBitValid = 1'b0;
      sarResult = 10'h000;
   end
   // Requests sampled on the rising edge, clear of the bench's own edge
   always @(posedge sys_clk) begin
      reqSeen <= {fireT2, fireT3};
      holdWas <= holdNow;
      holdNow <= holdConvert;
   end
   // Single-cycle overflows; data toggles when not valid, never stale
   always @(negedge sys_clk) begin
      {timer2Overflow, timer3Overflow} <= reqSeen & ~reqUsed;
      reqUsed <= reqSeen;
      sarBitValid <= holdWas && !holdNow;
      sarResult <= (holdWas && !holdNow) ? resultValue : ~sarResult;
   end
endmodule : sac_far_model

// File: tb/sac_conversion_control_tb.sv
// Bench for the converter control: registers, triggers, timing, results.
`timescale 1ns/100ps
module sac_conversion_control_tb
   import sac_pkg::*;
;
   logic       sys_clk = 1'b0;
   logic       rstn = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWrData = 8'h00;
   logic       regWrEn = 1'b0;
   logic       regRdEn = 1'b0;
   logic       externalConvertStart = 1'b0;
   logic       windowMatch = 1'b0;
   logic       fireT2 = 1'b0;
   logic       fireT3 = 1'b0;
   logic [9:0] resultValue = 10'h2c5;
   logic [7:0] regRdData, resultHighByte, resultLowByte, rdVal;
   logic [9:0] sarResult;
   logic [3:0] channelSelectCode;
   logic [2:0] muxPositive, amplifierGainCode, gainShift;
   logic       timer2Overflow, timer3Overflow, sarBitValid, gainHalf;
   logic       converterPowered, trackActive, holdConvert, sarStep;
   logic       conversionDoneIrq, tempSensorSelect, muxDifferential;
   int         fail_count = 0;
   int         checked = 0;
   int         hold, trk, irqs, steps;

   sac_conversion_control uut (.*);
   sac_far_model far (.*);

   initial begin
      forever #50 sys_clk = ~sys_clk;
   end

   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
   endtask : cmp

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      regAddr = a;
      regWrData = d;
      regWrEn = 1'b1;
      @(negedge sys_clk);
      regWrEn = 1'b0;
   endtask : wr

   // Read data is registered, so it is taken one cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(negedge sys_clk);
      regAddr = a;
      regRdEn = 1'b1;
      @(negedge sys_clk);
      regRdEn = 1'b0;
      rdVal = regRdData;
   endtask : rd

   // Fire one trigger; count tracking, holding and done pulses
   task automatic conv(input int kind, input logic [7:0] ctl);
      hold = 0;
      trk = 0;
      irqs = 0;
      steps = 0;
      wr(ADDR_CONV_CTRL, ctl);
      @(negedge sys_clk);
      case (kind)
         0: wr(ADDR_CONV_CTRL, ctl | 8'h10);
         1: fireT3 = 1'b1;
         2: fireT2 = 1'b1;
         default: externalConvertStart = 1'b1;
      endcase
      for (int n = 0; n < 400 && !(hold > 0 && !holdConvert); n++) begin
         @(negedge sys_clk);
         fireT2 = 1'b0;
         fireT3 = 1'b0;
         hold += int'(holdConvert);
         trk += int'(trackActive && hold == 0);
         steps += int'(sarStep);
         irqs += int'(conversionDoneIrq);
      end
      @(negedge sys_clk);
      irqs += int'(conversionDoneIrq);
   endtask : conv

   task automatic t_regs();
      logic [7:0] a [5] = '{8'hba, 8'hbb, 8'hbc, 8'he8, 8'h00};
      logic [7:0] e [5] = '{8'h00, 8'h00, 8'h60, 8'h00, 8'h00};
      logic [7:0] m [3] = '{8'h0f, 8'h0f, 8'he7};
      for (int i = 0; i < 5; i++) begin
         rd(a[i]);
         cmp(rdVal, e[i]);
      end
      for (int i = 0; i < 3; i++) begin
         wr(a[i], 8'hff);
         rd(a[i]);
         cmp(rdVal, m[i]);
      end
      $display("test regs done");
   endtask : t_regs

   task automatic t_fields();
      logic [3:0] c;
      for (int i = 0; i < 8; i++) begin
         wr(ADDR_CONV_CFG, 8'(i));
         repeat (2) @(negedge sys_clk);
         cmp(amplifierGainCode, 16'(i));
         cmp(gainHalf, 16'(i >= 6));
         if (i < 6) cmp(gainShift, 16'(i < 4 ? i : 4));
      end
      wr(ADDR_PAIR_CFG, 8'h05);
      for (int i = 0; i < 9; i += 2) begin
         c = 4'(i);
         wr(ADDR_CHAN_SEL, {4'h0, c});
         repeat (2) @(negedge sys_clk);
         cmp(tempSensorSelect, c[3]);
         if (!c[3]) begin
            cmp({muxDifferential, muxPositive}, {!c[1], c[2:0]});
         end
      end
      wr(ADDR_PAIR_CFG, 8'h00);
      wr(ADDR_CHAN_SEL, 8'h00);
      $display("test fields done");
   endtask : t_fields

   task automatic t_convert();
      for (int d = 0; d < 5; d++) begin
         wr(ADDR_CONV_CFG, {3'(d), 5'h00});
         conv(0, 8'h80);
         cmp(16'(hold), 16'(16 << (d < 4 ? d : 4)));
         cmp(16'(steps), 16'h10);
         cmp(16'(irqs), 16'h1);
         rd(ADDR_CONV_CTRL);
         cmp(rdVal, 8'ha0);
      end
      repeat (20) @(negedge sys_clk);
      rd(ADDR_CONV_CTRL);
      cmp(rdVal, 8'ha0);
      rd(ADDR_RES_HIGH);
      cmp(rdVal, 8'h02);
      rd(ADDR_RES_LOW);
      cmp(rdVal, 8'hc5);
      cmp({resultHighByte, resultLowByte}, 16'h02c5);
      wr(ADDR_CONV_CFG, 8'h20);
      conv(0, 8'hc0);
      cmp(16'(trk), 16'h6);
      cmp(16'(hold), 16'h20);
      wr(ADDR_CONV_CTRL, 8'h80);
      repeat (3) @(negedge sys_clk);
      cmp(trackActive, 1'b1);
      wr(ADDR_CONV_CTRL, 8'h00);
      repeat (3) @(negedge sys_clk);
      cmp({converterPowered, trackActive}, 2'h0);
      $display("test convert done");
   endtask : t_convert

   // Timer start modes answer only their own overflow; external mode starts on its pin
   task automatic t_trig();
      logic [7:0] m [5] = '{8'h84, 8'h84, 8'h84, 8'h8c, 8'h8c};
      int k [5] = '{0, 1, 2, 2, 1};
      int h [5] = '{0, 16, 0, 16, 0};
      wr(ADDR_CONV_CFG, 8'h00);
      for (int i = 0; i < 5; i++) begin
         conv(k[i], m[i]);
         cmp(16'(hold), 16'(h[i]));
      end
      wr(ADDR_CONV_CTRL, 8'hc8);
      repeat (5) @(negedge sys_clk);
      cmp(trackActive, 1'b1);
      conv(3, 8'hc8);
      cmp(16'(hold), 16'h10);
      cmp(trackActive, 1'b0);
      externalConvertStart = 1'b0;
      $display("test triggers done");
   endtask : t_trig

   task automatic t_result();
      wr(ADDR_PAIR_CFG, 8'h01);
      resultValue = 10'h3ff;
      conv(0, 8'h81);
      rd(ADDR_RES_HIGH);
      cmp(rdVal, 8'hff);
      rd(ADDR_RES_LOW);
      cmp(rdVal, 8'hc0);
      cmp({resultHighByte, resultLowByte}, 16'hffc0);
      resultValue = 10'h200;
      conv(0, 8'h80);
      rd(ADDR_RES_HIGH);
      cmp(rdVal, 8'hfe);
      rd(ADDR_RES_LOW);
      cmp(rdVal, 8'h00);
      cmp({resultHighByte, resultLowByte}, 16'hfe00);
      @(negedge sys_clk);
      windowMatch = 1'b1;
      @(negedge sys_clk);
      windowMatch = 1'b0;
      repeat (10) @(negedge sys_clk);
      rd(ADDR_CONV_CTRL);
      cmp(rdVal & 8'h22, 8'h22);
      wr(ADDR_CONV_CTRL, 8'h80);
      rd(ADDR_CONV_CTRL);
      cmp(rdVal, 8'h80);
      $display("test result done");
   endtask : t_result

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : give_verdict

   initial begin
      repeat (12) @(posedge sys_clk);
      @(negedge sys_clk);
      rstn = 1'b1;
      t_regs();
      t_fields();
      t_convert();
      t_trig();
      t_result();
      give_verdict();
   end

   // Run needs a few thousand cycles; a hang is cut off at 30000, well above that
   initial begin
      repeat (30000) @(posedge sys_clk);
      fail_count++;
      give_verdict();
   end
endmodule : sac_conversion_control_tb
